// File: core/sdrl_dev.sv
// Device end: read command decoder, latency counter and query table server
`timescale 1ns/1ns
module sdrl_dev (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Link
  sdrl_link_if.dev link,
  // User side
  input wire sdrl_pkg::sdrl_code_t latency_code,
  output logic [7:0] opcode_seen,
  output logic reject,
  output logic sending
);
  import sdrl_pkg::*;

  typedef enum logic [2:0] {D_CMD, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_SKIP} sdrl_dst_t;

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic cs_s1;
    logic cs_s2;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    sdrl_dst_t st;
    logic a4;
    sdrl_lg_t alg;
    sdrl_lg_t dlg;
    logic [7:0] cnt;
    logic [31:0] sh;
    logic [31:0] addr;
    logic [7:0] mode_n;
    logic [7:0] dmy_n;
    logic [7:0] ob;
    logic [3:0] nb;
    logic [3:0] io_o;
    logic [3:0] io_oe;
    logic [7:0] opcode;
    logic reject;
    logic sending;
  } sdrl_dstate_t;

  sdrl_dstate_t s_reg;
  sdrl_dstate_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic rise;
    logic fall;
    logic [7:0] op;
    logic [7:0] need;
    logic [31:0] sh_in;
    logic [7:0] b;
    logic [3:0] nb;
    sdrl_op_t dec;
    sdrl_lat_t lat;
    rise = s_reg.sck_s2 & ~s_reg.sck_d;
    fall = ~s_reg.sck_s2 & s_reg.sck_d;
    op = {s_reg.sh[6:0], s_reg.io_s2[0]};
    need = (s_reg.a4 ? ADDR4_BITS : ADDR3_BITS) >> s_reg.alg;
    dec = op_decode(op);
    lat = lat_of(latency_code, dec.cls);
    b = s_reg.ob;
    nb = s_reg.nb;
    sh_in = '0;
    unique case (s_reg.alg)
      2'h2: sh_in = {s_reg.sh[27:0], s_reg.io_s2};
      2'h1: sh_in = {s_reg.sh[29:0], s_reg.io_s2[1:0]};
      default: sh_in = {s_reg.sh[30:0], s_reg.io_s2[0]};
    endcase
    s_next = s_reg;
    // Pins are asynchronous to mclk
    s_next.sck_s1 = link.sck;
    s_next.sck_s2 = s_reg.sck_s1;
    s_next.sck_d = s_reg.sck_s2;
    s_next.cs_s1 = link.cs_n;
    s_next.cs_s2 = s_reg.cs_s1;
    s_next.io_s1 = link.io_lvl;
    s_next.io_s2 = s_reg.io_s1;
    s_next.reject = 1'b0;
    if (s_reg.cs_s2) begin
      s_next.st = D_CMD;
      s_next.cnt = '0;
      s_next.sh = '0;
      s_next.io_oe = '0;
      s_next.sending = 1'b0;
    end else begin
      unique case (s_reg.st)
        D_CMD: if (rise) begin
          s_next.sh = {s_reg.sh[30:0], s_reg.io_s2[0]};
          s_next.cnt = s_reg.cnt + 8'h01;
          if (s_reg.cnt == OP_BITS - 8'h01) begin
            s_next.opcode = op;
            s_next.cnt = '0;
            s_next.sh = '0;
            s_next.a4 = dec.a4;
            s_next.alg = addr_lg(dec.cls);
            s_next.dlg = data_lg(dec.cls);
            s_next.mode_n = lat.mode;
            s_next.dmy_n = lat.dummy;
            // Unsupported at this code: stay off the bus for the frame
            s_next.reject = dec.ok & ~lat.ok;
            s_next.st = (dec.ok && lat.ok) ? D_ADDR : D_SKIP;
          end
        end
        D_ADDR: if (rise) begin
          s_next.sh = sh_in;
          s_next.cnt = s_reg.cnt + 8'h01;
          if (s_reg.cnt == need - 8'h01) begin
            s_next.addr = sh_in;
            s_next.cnt = '0;
            s_next.nb = '0;
            s_next.st = (s_reg.mode_n != 8'h00) ? D_MODE :
                        (s_reg.dmy_n != 8'h00) ? D_DUMMY : D_DATA;
          end
        end
        D_MODE: if (rise) begin
          // Mode bits are counted only; no continuous read mode
          s_next.cnt = s_reg.cnt + 8'h01;
          if (s_reg.cnt == s_reg.mode_n - 8'h01) begin
            s_next.cnt = '0;
            s_next.st = (s_reg.dmy_n != 8'h00) ? D_DUMMY : D_DATA;
          end
        end
        D_DUMMY: if (rise) begin
          s_next.cnt = s_reg.cnt + 8'h01;
          if (s_reg.cnt == s_reg.dmy_n - 8'h01) begin
            s_next.cnt = '0;
            s_next.st = D_DATA;
          end
        end
        D_DATA: if (fall) begin
          if (nb == 4'h0) begin
            // Reads past the parameter return FFh
            b = (s_reg.addr < 32'(TBL_BYTES)) ?
                tbl_byte(int'(s_reg.addr[6:0])) : NO_SUPPORT;
            nb = BYTE_BITS;
            s_next.addr = s_reg.addr + 32'h1;
          end
          s_next.sending = 1'b1;
          unique case (s_reg.dlg)
            2'h2: begin
              s_next.io_o = b[7:4];
              s_next.io_oe = OE_X4;
              s_next.ob = {b[3:0], 4'h0};
              s_next.nb = nb - 4'h4;
            end
            2'h1: begin
              s_next.io_o = {2'b00, b[7:6]};
              s_next.io_oe = OE_X2;
              s_next.ob = {b[5:0], 2'b00};
              s_next.nb = nb - 4'h2;
            end
            default: begin
              s_next.io_o = {2'b00, b[7], 1'b0};
              s_next.io_oe = OE_X1_OUT;
              s_next.ob = {b[6:0], 1'b0};
              s_next.nb = nb - 4'h1;
            end
          endcase
        end
        D_SKIP: begin
          s_next.io_oe = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Table image layout is fixed in the package
  assign link.d_io_o = s_reg.io_o;
  assign link.d_io_oe = s_reg.io_oe;
  assign opcode_seen = s_reg.opcode;
  assign reject = s_reg.reject;
  assign sending = s_reg.sending;

endmodule : sdrl_dev

// File: core/sdrl_host.sv
// Host end: issues read commands with the cycles that the latency code asks
`timescale 1ns/1ns
module sdrl_host #(
  parameter int SCK_HALF = sdrl_pkg::SCK_HALF_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Link
  sdrl_link_if.host link,
  // Request
  input wire logic req,
  input wire logic [7:0] req_op,
  input wire logic [31:0] req_addr,
  input wire logic [7:0] req_len,
  input wire sdrl_pkg::sdrl_code_t latency_code,
  // Answer
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic reject
);
  import sdrl_pkg::*;

  localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
  localparam logic [7:0] SCK_MHZ = 8'(1000 / (2 * SCK_HALF * MCLK_NS));

  typedef enum logic [2:0] {H_IDLE, H_CMD, H_ADDR, H_MODE, H_DUMMY, H_DATA, H_END} sdrl_hst_t;

  typedef struct packed {
    sdrl_hst_t st;
    logic [7:0] div;
    logic sck;
    logic cs_n;
    logic [3:0] io_o;
    logic [3:0] io_oe;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    logic [39:0] sh;
    logic [7:0] cnt;
    logic a4;
    sdrl_lg_t alg;
    sdrl_lg_t dlg;
    logic [7:0] mode_n;
    logic [7:0] dmy_n;
    logic [7:0] nleft;
    logic [7:0] rx;
    logic [3:0] nb;
    logic busy;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic reject;
  } sdrl_hstate_t;

  sdrl_hstate_t s_reg;
  sdrl_hstate_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic tick;
    logic [7:0] cnt;
    logic [7:0] rx;
    logic [3:0] nb;
    sdrl_hst_t nst;
    sdrl_op_t dec;
    sdrl_lat_t lat;
    tick = (s_reg.div == HALF_M1);
    cnt = s_reg.cnt + 8'h01;
    nst = s_reg.st;
    rx = s_reg.rx;
    nb = s_reg.nb;
    dec = op_decode(req_op);
    lat = lat_of(latency_code, dec.cls);
    s_next = s_reg;
    s_next.io_s1 = link.io_lvl;
    s_next.io_s2 = s_reg.io_s1;
    s_next.rd_valid = 1'b0;
    s_next.done = 1'b0;
    s_next.reject = 1'b0;
    s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
    unique case (s_reg.st)
      H_IDLE: begin
        s_next.div = '0;
        if (req) begin
          // Refuse what the chosen row does not support or cannot clock
          if (!(dec.ok && lat.ok) || lat.freq < SCK_MHZ) begin
            s_next.reject = 1'b1;
          end else begin
            s_next.st = H_CMD;
            s_next.busy = 1'b1;
            s_next.cs_n = 1'b0;
            s_next.io_o = {3'b000, req_op[7]};
            s_next.io_oe = OE_X1_IN;
            s_next.sh = {req_op[6:0], dec.a4 ? req_addr : {req_addr[23:0], 8'h00}, 1'b0};
            s_next.cnt = '0;
            s_next.a4 = dec.a4;
            s_next.alg = addr_lg(dec.cls);
            s_next.dlg = data_lg(dec.cls);
            s_next.mode_n = lat.mode;
            s_next.dmy_n = lat.dummy;
            s_next.nleft = (req_len == 8'h00) ? 8'h01 : req_len;
            s_next.nb = '0;
          end
        end
      end
      H_END: if (tick) begin
        // Deselect held one half period before the next frame
        s_next.st = H_IDLE;
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
      H_CMD, H_ADDR, H_MODE, H_DUMMY, H_DATA: if (tick) begin
        s_next.sck = ~s_reg.sck;
        if (s_reg.sck) begin
          unique case (s_reg.st)
            H_CMD: if (cnt == OP_BITS) nst = H_ADDR;
            H_ADDR: if (cnt == ((s_reg.a4 ? ADDR4_BITS : ADDR3_BITS) >> s_reg.alg)) begin
              nst = (s_reg.mode_n != 8'h00) ? H_MODE :
                    (s_reg.dmy_n != 8'h00) ? H_DUMMY : H_DATA;
            end
            H_MODE: if (cnt == s_reg.mode_n) begin
              nst = (s_reg.dmy_n != 8'h00) ? H_DUMMY : H_DATA;
            end
            H_DUMMY: if (cnt == s_reg.dmy_n) nst = H_DATA;
            default: begin
              unique case (s_reg.dlg)
                2'h2: rx = {s_reg.rx[3:0], s_reg.io_s2};
                2'h1: rx = {s_reg.rx[5:0], s_reg.io_s2[1:0]};
                default: rx = {s_reg.rx[6:0], s_reg.io_s2[1]};
              endcase
              nb = s_reg.nb + (4'h1 << s_reg.dlg);
              if (nb == BYTE_BITS) begin
                nb = '0;
                s_next.rd_data = rx;
                s_next.rd_valid = 1'b1;
                s_next.nleft = s_reg.nleft - 8'h01;
                if (s_reg.nleft == 8'h01) nst = H_END;
              end
            end
          endcase
          s_next.rx = rx;
          s_next.nb = nb;
          s_next.st = nst;
          s_next.cnt = (nst != s_reg.st) ? 8'h00 : cnt;
          // Launch the next cycle on the falling edge
          s_next.io_oe = '0;
          if (nst == H_CMD) begin
            s_next.io_o = {3'b000, s_reg.sh[39]};
            s_next.io_oe = OE_X1_IN;
            s_next.sh = {s_reg.sh[38:0], 1'b0};
          end else if (nst == H_ADDR || nst == H_MODE) begin
            unique case (s_reg.alg)
              2'h2: begin
                s_next.io_o = s_reg.sh[39:36];
                s_next.io_oe = OE_X4;
                s_next.sh = {s_reg.sh[35:0], 4'h0};
              end
              2'h1: begin
                s_next.io_o = {2'b00, s_reg.sh[39:38]};
                s_next.io_oe = OE_X2;
                s_next.sh = {s_reg.sh[37:0], 2'b00};
              end
              default: begin
                s_next.io_o = {3'b000, s_reg.sh[39]};
                s_next.io_oe = OE_X1_IN;
                s_next.sh = {s_reg.sh[38:0], 1'b0};
              end
            endcase
          end else if (nst == H_END) begin
            s_next.cs_n = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // Deselected out of reset so the device never sees a false frame
      s_reg <= '0;
      s_reg.cs_n <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign link.sck = s_reg.sck;
  assign link.cs_n = s_reg.cs_n;
  assign link.h_io_o = s_reg.io_o;
  assign link.h_io_oe = s_reg.io_oe;
  assign busy = s_reg.busy;
  assign rd_data = s_reg.rd_data;
  assign rd_valid = s_reg.rd_valid;
  assign done = s_reg.done;
  assign reject = s_reg.reject;

endmodule : sdrl_host

// File: core/sdrl_link_if.sv
// Serial link between host and device ends, with pin level resolution
`timescale 1ns/1ns
interface sdrl_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io_lvl;

  // Undriven lines read high, as through a pull-up
  assign io_lvl = (h_io_oe & h_io_o) | (d_io_oe & d_io_o) | ~(h_io_oe | d_io_oe);

  modport host (output sck, output cs_n, output h_io_o, output h_io_oe, input io_lvl);
  modport dev (input sck, input cs_n, input io_lvl, output d_io_o, output d_io_oe);
endinterface : sdrl_link_if

// File: core/sdrl_pkg.sv
// Shared constants, query table image and lookups for the read latency link
package sdrl_pkg;

  typedef logic [1:0] sdrl_code_t;
  typedef logic [1:0] sdrl_lg_t;

  typedef struct packed {
    logic ok;
    logic a4;
    logic [2:0] cls;
  } sdrl_op_t;

  typedef struct packed {
    logic ok;
    logic [7:0] freq;
    logic [7:0] mode;
    logic [7:0] dummy;
  } sdrl_lat_t;

  ////////////////////////////////////////////////////////////////////////////
  localparam int TBL_BYTES = 88;
  localparam int NUM_ROWS = 6;
  localparam int ROW_LEN = 14;
  localparam int ROW0_OFS = 4;
  localparam int HDR_OP_OFS = 6;
  localparam int NUM_CLS = 6;
  localparam logic [7:0] NO_SUPPORT = 8'hFF;
  localparam logic [7:0] ADDR3_BITS = 8'h18;
  localparam logic [7:0] ADDR4_BITS = 8'h20;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] OP_BITS = 8'h08;
  localparam logic [3:0] OE_X1_IN = 4'h1;
  localparam logic [3:0] OE_X1_OUT = 4'h2;
  localparam logic [3:0] OE_X2 = 4'h3;
  localparam logic [3:0] OE_X4 = 4'hF;
  localparam int MCLK_NS = 20;
  localparam int SCK_NS = 160;
  localparam int SCK_HALF_CYC = SCK_NS / (2 * MCLK_NS);

  // Command classes, in header order
  localparam logic [2:0] CLS_DOUT = 3'h2;
  localparam logic [2:0] CLS_QOUT = 3'h3;
  localparam logic [2:0] CLS_DIO = 3'h4;
  localparam logic [2:0] CLS_QIO = 3'h5;

  // Read opcodes, 3-byte then 4-byte address form
  localparam logic [7:0] OP_RD3 = 8'h03;
  localparam logic [7:0] OP_RD4 = 8'h13;
  localparam logic [7:0] OP_FR3 = 8'h0B;
  localparam logic [7:0] OP_FR4 = 8'h0C;
  localparam logic [7:0] OP_DO3 = 8'h3B;
  localparam logic [7:0] OP_DO4 = 8'h3C;
  localparam logic [7:0] OP_QO3 = 8'h6B;
  localparam logic [7:0] OP_QO4 = 8'h6C;
  localparam logic [7:0] OP_DIO3 = 8'hBB;
  localparam logic [7:0] OP_DIO4 = 8'hBC;
  localparam logic [7:0] OP_QIO3 = 8'hEB;
  localparam logic [7:0] OP_QIO4 = 8'hEC;

  // Parameter image: id, length, rows, row length, header row, five rows
  localparam logic [8*TBL_BYTES-1:0] TABLE = {
    8'h90, 8'h56, 8'h06, 8'h0E,
    8'h46, 8'h43, OP_RD3, OP_RD4, OP_FR3, OP_FR4, OP_DO3, OP_DO4,
    OP_QO3, OP_QO4, OP_DIO3, OP_DIO4, OP_QIO3, OP_QIO4,
    8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h04, 8'h00, 8'h02, 8'h01,
    8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h04, 8'h00, 8'h02, 8'h04,
    8'h5A, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h04, 8'h01, 8'h02, 8'h04,
    8'h68, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h04, 8'h02, 8'h02, 8'h05,
    8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF
  };

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] tbl_byte(input int idx);
    if (idx < 0 || idx >= TBL_BYTES) begin
      return NO_SUPPORT;
    end
    return TABLE[8*(TBL_BYTES-1-idx) +: 8];
  endfunction : tbl_byte

  // Opcodes are matched against the header row itself
  function automatic sdrl_op_t op_decode(input logic [7:0] op);
    sdrl_op_t d;
    d = '0;
    for (int c = 0; c < NUM_CLS; c++) begin
      for (int w = 0; w < 2; w++) begin
        if (op == tbl_byte(HDR_OP_OFS + 2*c + w)) begin
          d.ok = 1'b1;
          d.a4 = w[0];
          d.cls = c[2:0];
        end
      end
    end
    return d;
  endfunction : op_decode

  // Lowest matching row wins; code 10b therefore takes the 104 MHz row
  function automatic sdrl_lat_t lat_of(input sdrl_code_t code, input logic [2:0] cls);
    sdrl_lat_t l;
    int b;
    l = '0;
    for (int r = NUM_ROWS-1; r >= 1; r--) begin
      b = ROW0_OFS + r*ROW_LEN;
      if (tbl_byte(b+1) == {6'h00, code}) begin
        l.freq = tbl_byte(b);
        l.mode = tbl_byte(b + 2 + 2*int'(cls));
        l.dummy = tbl_byte(b + 3 + 2*int'(cls));
        l.ok = (l.mode != NO_SUPPORT) && (l.dummy != NO_SUPPORT);
      end
    end
    return l;
  endfunction : lat_of

  function automatic sdrl_lg_t addr_lg(input logic [2:0] cls);
    return (cls == CLS_QIO) ? 2'h2 : (cls == CLS_DIO) ? 2'h1 : 2'h0;
  endfunction : addr_lg

  function automatic sdrl_lg_t data_lg(input logic [2:0] cls);
    if (cls == CLS_QIO || cls == CLS_QOUT) begin
      return 2'h2;
    end
    return (cls == CLS_DIO || cls == CLS_DOUT) ? 2'h1 : 2'h0;
  endfunction : data_lg

endpackage : sdrl_pkg

// File: verif/sdrl_monitor.sv
// Link checker: timing and pin ownership rules watched on the shared wires
`timescale 1ns/1ns
module sdrl_monitor #(
  parameter int SCK_HALF = 4
) (
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Link wires
  input logic sck,
  input logic cs_n,
  input logic [3:0] h_io_o,
  input logic [3:0] h_io_oe,
  input logic [3:0] d_io_o,
  input logic [3:0] d_io_oe,
  input logic [3:0] io_lvl
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last link edge, and rises seen in this frame
  logic sck_d_reg;
  logic cs_d_reg;
  int run_reg;
  int rise_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      run_reg <= 0;
      rise_reg <= 0;
    end else begin
      sck_d_reg <= sck;
      cs_d_reg <= cs_n;
      run_reg <= (sck != sck_d_reg || cs_n != cs_d_reg) ? 1 : run_reg + 1;
      rise_reg <= cs_n ? 0 : (sck && !sck_d_reg) ? rise_reg + 1 : rise_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence frame_start;
    $fell(cs_n);
  endsequence
  // Opcode goes out on one lane, first rise a half period later
  sequence opcode_lead;
    (h_io_oe == 4'h1 && !sck) [*4] ##1 sck;
  endsequence
  frame_open_a: assert property (frame_start |-> opcode_lead)
    else $error("frame did not open with a single-lane opcode");
  half_period_a: assert property (!cs_n && $changed(sck) |-> run_reg == SCK_HALF)
    else $error("link clock half period wrong");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("link clock not low outside a frame");
  release_a: assert property (cs_n [*4] |-> h_io_oe == 4'h0 && d_io_oe == 4'h0)
    else $error("pins still driven outside a frame");
  no_clash_a: assert property ((h_io_oe & d_io_oe) == 4'h0)
    else $error("both ends drive one line");
  opcode_quiet_a: assert property (!cs_n && rise_reg < 8 |-> d_io_oe == 4'h0)
    else $error("device drove during the opcode");
  dev_hold_a: assert property (sck && $past(sck) |->
    $stable(d_io_oe) && $stable(d_io_o & d_io_oe))
    else $error("device data moved while clock high");
  host_hold_a: assert property (sck && $past(sck) |->
    $stable(h_io_oe) && $stable(h_io_o & h_io_oe))
    else $error("host lines moved while clock high");
endmodule : sdrl_monitor

// File: verif/tb.sv
// Self-checking bench: host and device ends joined over the link
`timescale 1ns/1ns
module tb;
  import sdrl_pkg::*;
  localparam int HALF = 4;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic req = 1'b0;
  logic [7:0] req_op = 8'h00;
  logic [31:0] req_addr = 32'h0;
  logic [7:0] req_len = 8'h00;
  sdrl_code_t h_code = 2'h3;
  sdrl_code_t d_code = 2'h3;
  logic h_busy, h_valid, h_done, h_rej, d_rej, d_send;
  logic [7:0] h_data, d_op;
  logic rej_seen = 1'b0;
  logic send_seen = 1'b0;
  logic [7:0] got [$];
  int rises = 0;
  int fail_count = 0;
  int n_checks = 0;
  logic [7:0] ops [12] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C,
                           8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC};
  int al [6] = '{1, 1, 1, 1, 2, 4};
  int dl [6] = '{1, 1, 2, 4, 2, 4};
  int m11 [6] = '{0, 0, 0, 0, 4, 2};
  int d11 [6] = '{0, 0, 0, 0, 0, 1};
  int d00 [6] = '{0, 8, 8, 8, 0, 4};

  sdrl_link_if link ();
  always #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  sdrl_host #(.SCK_HALF(HALF)) sdrl_host_inst (.mclk(mclk), .rstn(rstn), .ce(ce),
    .link(link.host), .req(req), .req_op(req_op), .req_addr(req_addr), .req_len(req_len),
    .latency_code(h_code), .busy(h_busy), .rd_data(h_data), .rd_valid(h_valid),
    .done(h_done), .reject(h_rej));
  sdrl_dev sdrl_dev_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .link(link.dev),
    .latency_code(d_code), .opcode_seen(d_op), .reject(d_rej), .sending(d_send));
  sdrl_monitor #(.SCK_HALF(HALF)) sdrl_monitor_inst (.mclk(mclk), .rstn(rstn),
    .sck(link.sck), .cs_n(link.cs_n), .h_io_o(link.h_io_o), .h_io_oe(link.h_io_oe),
    .d_io_o(link.d_io_o), .d_io_oe(link.d_io_oe), .io_lvl(link.io_lvl));
  ////////////////////////////////////////////////////////////////////////////
  // Short pulses are latched so a frame can be judged after it ends
  always @(posedge mclk) begin
    if (d_rej === 1'b1) rej_seen <= 1'b1;
    if (d_send === 1'b1) send_seen <= 1'b1;
  end
  always @(posedge link.sck) rises++;

  task automatic chk_b(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_b

  task automatic chk_n(input string what, input int exp, input int seen);
    n_checks++;
    if (seen != exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk_n

  task automatic set_code(input sdrl_code_t h, input sdrl_code_t d);
    @(posedge mclk);
    h_code <= h;
    d_code <= d;
  endtask : set_code

  // One request, then wait for done or refusal under a bound
  task automatic xfer(input logic [7:0] op, input logic [31:0] addr, input int len);
    int k;
    got.delete();
    rises = 0;
    rej_seen = 1'b0;
    send_seen = 1'b0;
    @(posedge mclk);
    req <= 1'b1;
    req_op <= op;
    req_addr <= addr;
    req_len <= 8'(len);
    // First look is right after the taking edge, where a refusal pulses
    for (k = 0; k < 20000; k++) begin
      @(posedge mclk);
      req <= 1'b0;
      #1;
      if (h_valid === 1'b1) got.push_back(h_data);
      if (h_done === 1'b1 || h_rej === 1'b1) break;
    end
    if (k == 20000) chk_n("completion", 0, 1);
  endtask : xfer

  // Read, compare bytes, opcode seen and clock count of the whole frame
  task automatic rd(input int i, input logic [31:0] addr, input logic [7:0] exp [$],
                    input int m, input int d);
    xfer(ops[i], addr, exp.size());
    chk_n("bytes", exp.size(), got.size());
    foreach (exp[j]) chk_b("data", exp[j], (j < got.size()) ? got[j] : 8'hXX);
    chk_b("opcode seen", ops[i], d_op);
    chk_b("busy after done", 8'h00, {7'h00, h_busy});
    chk_b("device sent", 8'h01, {7'h00, send_seen});
    chk_n("sck rises", 8 + ((i % 2) ? 32 : 24) / al[i/2] + m + d
          + exp.size() * 8 / dl[i/2], rises);
  endtask : rd

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // About 10k cycles expected; cut off well beyond
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(2, 0, '{8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43}, 0, 0);
    for (int i = 0; i < 12; i++) begin
      rd(i, 6 + i, '{ops[i]}, m11[i/2], d11[i/2]);
    end
    rd(2, 32'h12, '{8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
       8'h04, 8'h00, 8'h02, 8'h01}, 0, 0);
    set_code(2'h0, 2'h0);
    for (int i = 2; i < 12; i++) begin
      rd(i, 32'h20, '{8'h50, 8'h00}, m11[i/2], d00[i/2]);
    end
    // Host must refuse the basic read here without opening a frame
    xfer(8'h03, 0, 1);
    chk_b("host refusal", 8'h01, {7'h00, h_rej});
    chk_n("refused rises", 0, rises);
    // An opcode outside the header row is refused before any frame
    xfer(8'hA5, 0, 1);
    chk_b("unknown refusal", 8'h01, {7'h00, h_rej});
    chk_n("unknown rises", 0, rises);
    // Ends disagree: device refuses and leaves the lines to the pull-up
    set_code(2'h3, 2'h0);
    xfer(8'h03, 0, 1);
    chk_b("device refusal", 8'h01, {7'h00, rej_seen});
    chk_b("device quiet", 8'h00, {7'h00, send_seen});
    chk_b("idle data", 8'hFF, (got.size() > 0) ? got[0] : 8'hXX);
    set_code(2'h1, 2'h1);
    rd(2, 32'h2E, '{8'h5A, 8'h01}, 0, 8);
    set_code(2'h2, 2'h2);
    rd(11, 32'h48, '{8'h02, 8'h05}, 2, 5);
    rd(2, 32'h4A, '{8'h85, 8'h02}, 0, 8);
    end_of_test();
  end
endmodule : tb
